// >>> shared/lscr_pkg.sv
// shared constants and carrier types for the lane signal conditioning registers
package lscr_pkg;
    // register offsets
    localparam logic [7:0] OFS_B0_DEEMPH = 8'h35;
    localparam logic [7:0] OFS_A1_IDLE_RATE = 8'h39;
    localparam logic [7:0] OFS_IN1_RX_BOOST = 8'h3A;
    localparam logic [7:0] OFS_A1_SWING = 8'h3B;
    localparam logic [7:0] OFS_A1_DEEMPH = 8'h3C;
    localparam logic [7:0] OFS_IN1_IDLE_THR = 8'h3D;
    localparam logic [7:0] OFS_B1_IDLE_RATE = 8'h40;
    localparam logic [7:0] OFS_B1_SWING = 8'h42;
    localparam logic [7:0] OFS_B1_DEEMPH = 8'h43;
    localparam logic [7:0] OFS_SWING_TRIM = 8'h47;
    // power-on values
    localparam logic [7:0] RST_DEEMPH = 8'h03;
    localparam logic [7:0] RST_IDLE_RATE = 8'h00;
    localparam logic [7:0] RST_RX_BOOST = 8'h20;
    localparam logic [7:0] RST_SWING = 8'h03;
    localparam logic [7:0] RST_IDLE_THR = 8'h00;
    localparam logic [7:0] RST_SWING_TRIM = 8'h02;
    // field positions
    localparam int DEEMPH_TYPE_BIT = 7;
    localparam int IDLE_AUTO_BIT = 5;
    localparam int IDLE_SEL_BIT = 4;
    localparam int RATE_AUTO_BIT = 1;
    localparam int RATE_SEL_BIT = 0;
    localparam int RX_EN_BIT = 5;
    localparam int THR_DEASSERT_LSB = 2;
    localparam int THR_ASSERT_LSB = 0;
    // writable field masks
    localparam logic [7:0] MASK_IDLE_RATE = 8'h33;
    localparam logic [7:0] MASK_RX_BOOST = 8'h3F;
    localparam logic [7:0] MASK_SWING = 8'h7F;
    localparam logic [7:0] MASK_IDLE_THR = 8'h0F;
    localparam logic [7:0] MASK_SWING_TRIM = 8'h03;
    // default bus address, value is arbitrary
    localparam logic [6:0] DEF_DEV_ADDR = 7'h2A;

    // one register write
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } lscr_wr_type;

    // de-emphasis control for one output
    typedef struct packed {
        logic enhanced;
        logic [2:0] step;
        logic valid;
    } lscr_deemph_type;

    // full conditioning control for one output
    typedef struct packed {
        lscr_deemph_type deemph;
        logic [10:0] swing_mv;
        logic swing_valid;
        logic auto_idle;
        logic muted;
        logic auto_rate;
        logic high_rate;
    } lscr_tx_type;

    // input controls
    typedef struct packed {
        logic boost_en;
        logic [1:0] gain_stage;
        logic [2:0] boost_level;
        logic [3:0] boost_step;
        logic boost_valid;
        logic [7:0] deassert_mv;
        logic [7:0] assert_mv;
    } lscr_rx_type;
endpackage : lscr_pkg

// >>> verilog/lscr_smbus_slave.sv
// management bus slave with a register pointer
`timescale 1ns/1ns
`default_nettype none
module lscr_smbus_slave #(
    parameter logic [6:0] DEV_ADDR = lscr_pkg::DEF_DEV_ADDR
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus pins, taken as synchronous
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // register side
    output lscr_pkg::lscr_wr_type wr,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } lscr_state_type;

    lscr_state_type state_reg; // transfer phase
    logic scl_reg; // previous scl sample
    logic sda_reg; // previous sda sample
    logic [3:0] cnt_reg; // bits moved in this byte
    logic [7:0] shift_reg; // byte being moved
    logic read_reg; // direction bit of the address byte
    logic [7:0] ptr_reg; // register pointer

    // line events
    wire scl_rise = scl_in & ~scl_reg;
    wire scl_fall = ~scl_in & scl_reg;
    wire start_seen = scl_in & scl_reg & sda_reg & ~sda_in;
    wire stop_seen = scl_in & scl_reg & ~sda_reg & sda_in;
    wire rx_phase = (state_reg == ST_ADDR) | (state_reg == ST_CMD) | (state_reg == ST_WDATA);
    wire byte_in = rx_phase & scl_fall & (cnt_reg == 4'h8);
    wire addr_hit = (shift_reg[7:1] == DEV_ADDR);

    assign rd_addr = ptr_reg;

    // line sampling
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else begin
            scl_reg <= scl_in;
            sda_reg <= sda_in;
        end
    end

    // protocol engine; start and stop win over any bit activity
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            read_reg <= 1'b0;
            ptr_reg <= 8'h00;
            sda_oe_n <= 1'b1;
            sda_out <= 1'b0;
            wr <= '0;
        end else begin
            wr.en <= 1'b0;
            if (start_seen) begin
                state_reg <= ST_ADDR;
                cnt_reg <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (stop_seen) begin
                state_reg <= ST_IDLE;
                sda_oe_n <= 1'b1;
            end else if (rx_phase & scl_rise & (cnt_reg != 4'h8)) begin
                shift_reg <= {shift_reg[6:0], sda_in};
                cnt_reg <= cnt_reg + 4'h1;
            end else if (byte_in) begin
                cnt_reg <= 4'h0;
                case (state_reg)
                    ST_ADDR: begin
                        // stay silent for other addresses
                        state_reg <= addr_hit ? ST_ADDR_ACK : ST_IDLE;
                        sda_oe_n <= ~addr_hit;
                        read_reg <= shift_reg[0];
                    end
                    ST_CMD: begin
                        ptr_reg <= shift_reg;
                        state_reg <= ST_CMD_ACK;
                        sda_oe_n <= 1'b0;
                    end
                    default: begin
                        wr <= '{en: 1'b1, addr: ptr_reg, data: shift_reg};
                        state_reg <= ST_WDATA_ACK;
                        sda_oe_n <= 1'b0;
                    end
                endcase
            end else if (scl_fall) begin
                case (state_reg)
                    ST_ADDR_ACK: begin
                        if (read_reg) begin
                            // first read bit goes out as the ack ends
                            state_reg <= ST_RDATA;
                            sda_oe_n <= rd_data[7];
                            shift_reg <= {rd_data[6:0], 1'b0};
                            cnt_reg <= 4'h1;
                        end else begin
                            state_reg <= ST_CMD;
                            sda_oe_n <= 1'b1;
                        end
                    end
                    ST_CMD_ACK: begin
                        state_reg <= ST_WDATA;
                        sda_oe_n <= 1'b1;
                    end
                    ST_WDATA_ACK: begin
                        // further bytes fill following offsets
                        ptr_reg <= ptr_reg + 8'h01;
                        state_reg <= ST_WDATA;
                        sda_oe_n <= 1'b1;
                    end
                    ST_RDATA: begin
                        if (cnt_reg == 4'h8) begin
                            state_reg <= ST_RDATA_ACK;
                            sda_oe_n <= 1'b1;
                        end else begin
                            sda_oe_n <= shift_reg[7];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                    ST_RDATA_ACK: begin
                        // master acked: stream the next offset
                        state_reg <= ST_ADDR_ACK;
                        ptr_reg <= ptr_reg + 8'h01;
                    end
                    default: begin
                        sda_oe_n <= 1'b1;
                    end
                endcase
            end else if (scl_rise & (state_reg == ST_RDATA_ACK) & sda_in) begin
                // not acked: read ends, wait for stop
                state_reg <= ST_IDLE;
            end
        end
    end
endmodule : lscr_smbus_slave
`default_nettype wire

// >>> verilog/lscr_regs.sv
// signal conditioning register bank for the second lane, lane 0 output b de-emphasis and shared trim
//
// Function
// - bit 7 selects compatibility or enhanced de-emphasis
// - de-emphasis byte codes map to five levels
// - idle auto bit overrides manual idle select
// - manual idle: 0 drives, 1 mutes output
// - rate auto bit overrides manual rate select
// - equalizer field: enable, gain stage, boost level
// - equalizer codes decode bypass and eight boosts
// - swing codes 600 to 1200 mV, 3Fh reserved
// - threshold nibble holds de-assert and assert codes
// - global trim scales every output swing
`timescale 1ns/1ns
`default_nettype none
module lscr_regs #(
    parameter logic [6:0] DEV_ADDR = lscr_pkg::DEF_DEV_ADDR
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // management bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // lane 0 output b de-emphasis
    output lscr_pkg::lscr_deemph_type lane0_output_b,
    // lane 1 outputs a and b
    output lscr_pkg::lscr_tx_type lane1_output_a,
    output lscr_pkg::lscr_tx_type lane1_output_b,
    // lane 1 input conditioning
    output lscr_pkg::lscr_rx_type lane1_input
);
    // ports: 0 = lane 1 output a, 1 = lane 1 output b, 2 = lane 0 output b
    localparam int NUM_TX = 2;
    localparam int NUM_DE = 3;

    lscr_pkg::lscr_wr_type wr; // write request from the bus
    logic [7:0] rd_addr; // read pointer from the bus
    logic [7:0] rd_data; // read data to the bus

    // stored fields
    logic [7:0] deemph_reg [NUM_DE]; // full de-emphasis bytes
    logic [7:0] idle_rate_reg [NUM_TX]; // idle/rate fields, reserved bits dropped
    logic [7:0] swing_reg [NUM_TX]; // swing fields
    logic [7:0] rx_boost_reg; // equalizer field
    logic [7:0] idle_thr_reg; // threshold nibble
    logic [7:0] swing_trim_reg; // global trim

    // decoded controls
    lscr_pkg::lscr_deemph_type deemph_next [NUM_DE];
    lscr_pkg::lscr_tx_type tx_next [NUM_TX];
    lscr_pkg::lscr_rx_type rx_next;

    // bus slave
    lscr_smbus_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_bus (
        .clk(clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n),
        .wr(wr),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // de-emphasis byte to level step: 0 dB, -3.5, -6, -9, -12
    function automatic lscr_pkg::lscr_deemph_type deemph_decode(input logic [7:0] code);
        lscr_pkg::lscr_deemph_type d;
        d.enhanced = code[lscr_pkg::DEEMPH_TYPE_BIT];
        d.valid = 1'b1;
        case (code)
            8'h01: d.step = 3'h0;
            8'hE8: d.step = 3'h1;
            8'h88: d.step = 3'h2;
            8'h90: d.step = 3'h3;
            8'hA0: d.step = 3'h4;
            default: begin
                // unlisted codes apply no de-emphasis
                d.step = 3'h0;
                d.valid = 1'b0;
            end
        endcase
        return d;
    endfunction : deemph_decode

    // swing code to millivolts before trim
    function automatic logic [11:0] swing_decode(input logic [6:0] code);
        logic [11:0] r;
        case (code)
            7'h03: r = {1'b1, 11'd600};
            7'h07: r = {1'b1, 11'd800};
            7'h0F: r = {1'b1, 11'd1000};
            7'h1F: r = {1'b1, 11'd1200};
            // others fall back to default swing
            default: r = {1'b0, 11'd600};
        endcase
        return r;
    endfunction : swing_decode

    // trim factor in eighths: 6, 7, 8, 9
    wire [3:0] trim_eighths = 4'h6 + {2'b00, swing_trim_reg[1:0]};

    // per output decode
    generate
        for (genvar i = 0; i < NUM_TX; i++) begin : g_tx
            wire [11:0] sw = swing_decode(swing_reg[i][6:0]);
            wire [14:0] scaled = sw[10:0] * trim_eighths;
            wire idle_auto = idle_rate_reg[i][lscr_pkg::IDLE_AUTO_BIT];
            wire rate_auto = idle_rate_reg[i][lscr_pkg::RATE_AUTO_BIT];
            always_comb begin
                tx_next[i].deemph = deemph_decode(deemph_reg[i]);
                tx_next[i].swing_mv = scaled[13:3];
                tx_next[i].swing_valid = sw[11];
                // auto mode hides the manual bit but keeps it stored
                tx_next[i].auto_idle = idle_auto;
                tx_next[i].muted = ~idle_auto
                    & idle_rate_reg[i][lscr_pkg::IDLE_SEL_BIT];
                tx_next[i].auto_rate = rate_auto;
                tx_next[i].high_rate = ~rate_auto
                    & idle_rate_reg[i][lscr_pkg::RATE_SEL_BIT];
            end
        end
        for (genvar j = 0; j < NUM_DE; j++) begin : g_de
            assign deemph_next[j] = deemph_decode(deemph_reg[j]);
        end
    endgenerate

    // equalizer and threshold decode
    always_comb begin
        rx_next.boost_en = rx_boost_reg[lscr_pkg::RX_EN_BIT];
        rx_next.gain_stage = rx_boost_reg[4:3];
        rx_next.boost_level = rx_boost_reg[2:0];
        rx_next.boost_valid = 1'b1;
        // step 0 is bypass, 1..8 rise from 5 dB to 28.4 dB
        case (rx_boost_reg[5:0])
            6'h20: rx_next.boost_step = 4'h0;
            6'h2A: rx_next.boost_step = 4'h1;
            6'h30: rx_next.boost_step = 4'h2;
            6'h32: rx_next.boost_step = 4'h3;
            6'h39: rx_next.boost_step = 4'h4;
            6'h35: rx_next.boost_step = 4'h5;
            6'h37: rx_next.boost_step = 4'h6;
            6'h3B: rx_next.boost_step = 4'h7;
            6'h3D: rx_next.boost_step = 4'h8;
            default: begin
                // raw fields still drive the equalizer; only the step is unknown
                rx_next.boost_step = 4'hF;
                rx_next.boost_valid = 1'b0;
            end
        endcase
        case (idle_thr_reg[lscr_pkg::THR_DEASSERT_LSB +: 2])
            2'b00: rx_next.deassert_mv = 8'd110;
            2'b01: rx_next.deassert_mv = 8'd150;
            2'b10: rx_next.deassert_mv = 8'd170;
            default: rx_next.deassert_mv = 8'd190;
        endcase
        case (idle_thr_reg[lscr_pkg::THR_ASSERT_LSB +: 2])
            2'b00: rx_next.assert_mv = 8'd70;
            2'b01: rx_next.assert_mv = 8'd110;
            2'b10: rx_next.assert_mv = 8'd130;
            default: rx_next.assert_mv = 8'd150;
        endcase
    end

    // write decode
    wire wr_b0_de = wr.en & (wr.addr == lscr_pkg::OFS_B0_DEEMPH);
    wire wr_a1_ir = wr.en & (wr.addr == lscr_pkg::OFS_A1_IDLE_RATE);
    wire wr_rx = wr.en & (wr.addr == lscr_pkg::OFS_IN1_RX_BOOST);
    wire wr_a1_sw = wr.en & (wr.addr == lscr_pkg::OFS_A1_SWING);
    wire wr_a1_de = wr.en & (wr.addr == lscr_pkg::OFS_A1_DEEMPH);
    wire wr_thr = wr.en & (wr.addr == lscr_pkg::OFS_IN1_IDLE_THR);
    wire wr_b1_ir = wr.en & (wr.addr == lscr_pkg::OFS_B1_IDLE_RATE);
    wire wr_b1_sw = wr.en & (wr.addr == lscr_pkg::OFS_B1_SWING);
    wire wr_b1_de = wr.en & (wr.addr == lscr_pkg::OFS_B1_DEEMPH);
    wire wr_trim = wr.en & (wr.addr == lscr_pkg::OFS_SWING_TRIM);

    // register storage; reserved bits are not stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            deemph_reg[0] <= lscr_pkg::RST_DEEMPH;
            deemph_reg[1] <= lscr_pkg::RST_DEEMPH;
            deemph_reg[2] <= lscr_pkg::RST_DEEMPH;
            idle_rate_reg[0] <= lscr_pkg::RST_IDLE_RATE;
            idle_rate_reg[1] <= lscr_pkg::RST_IDLE_RATE;
            swing_reg[0] <= lscr_pkg::RST_SWING;
            swing_reg[1] <= lscr_pkg::RST_SWING;
            rx_boost_reg <= lscr_pkg::RST_RX_BOOST;
            idle_thr_reg <= lscr_pkg::RST_IDLE_THR;
            swing_trim_reg <= lscr_pkg::RST_SWING_TRIM;
        end else begin
            if (wr_a1_de) deemph_reg[0] <= wr.data;
            if (wr_b1_de) deemph_reg[1] <= wr.data;
            if (wr_b0_de) deemph_reg[2] <= wr.data;
            // manual bits kept even under auto control
            if (wr_a1_ir) idle_rate_reg[0] <= wr.data & lscr_pkg::MASK_IDLE_RATE;
            if (wr_b1_ir) idle_rate_reg[1] <= wr.data & lscr_pkg::MASK_IDLE_RATE;
            if (wr_a1_sw) swing_reg[0] <= wr.data & lscr_pkg::MASK_SWING;
            if (wr_b1_sw) swing_reg[1] <= wr.data & lscr_pkg::MASK_SWING;
            if (wr_rx) rx_boost_reg <= wr.data & lscr_pkg::MASK_RX_BOOST;
            if (wr_thr) idle_thr_reg <= wr.data & lscr_pkg::MASK_IDLE_THR;
            if (wr_trim) swing_trim_reg <= wr.data & lscr_pkg::MASK_SWING_TRIM;
        end
    end

    // read selection; unmapped offsets read zero
    assign rd_data =
        (rd_addr == lscr_pkg::OFS_B0_DEEMPH) ? deemph_reg[2] :
        (rd_addr == lscr_pkg::OFS_A1_IDLE_RATE) ? idle_rate_reg[0] :
        (rd_addr == lscr_pkg::OFS_IN1_RX_BOOST) ? rx_boost_reg :
        (rd_addr == lscr_pkg::OFS_A1_SWING) ? swing_reg[0] :
        (rd_addr == lscr_pkg::OFS_A1_DEEMPH) ? deemph_reg[0] :
        (rd_addr == lscr_pkg::OFS_IN1_IDLE_THR) ? idle_thr_reg :
        (rd_addr == lscr_pkg::OFS_B1_IDLE_RATE) ? idle_rate_reg[1] :
        (rd_addr == lscr_pkg::OFS_B1_SWING) ? swing_reg[1] :
        (rd_addr == lscr_pkg::OFS_B1_DEEMPH) ? deemph_reg[1] :
        (rd_addr == lscr_pkg::OFS_SWING_TRIM) ? swing_trim_reg : 8'h00;

    // output flops, one cycle behind the registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lane0_output_b <= '0;
            lane1_output_a <= '0;
            lane1_output_b <= '0;
            lane1_input <= '0;
        end else begin
            lane0_output_b <= deemph_next[2];
            lane1_output_a <= tx_next[0];
            lane1_output_b <= tx_next[1];
            lane1_input <= rx_next;
        end
    end
endmodule : lscr_regs
`default_nettype wire

// >>> sim/lscr_regs_properties.sv
// port checks for the register bank
`timescale 1ns/1ns
`default_nettype none
module lscr_regs_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // control outputs
    input wire lscr_pkg::lscr_deemph_type lane0_output_b,
    input wire lscr_pkg::lscr_tx_type lane1_output_a,
    input wire lscr_pkg::lscr_tx_type lane1_output_b,
    input wire lscr_pkg::lscr_rx_type lane1_input
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // boost codes by rising boost
    localparam logic [5:0] BC [9] = '{6'h20, 6'h2A, 6'h30, 6'h32, 6'h39, 6'h35, 6'h37, 6'h3B, 6'h3D};
    // code to step, 15 if unlisted
    function automatic logic [3:0] bdec(input logic [5:0] c);
        logic [3:0] s;
        s = 4'hF;
        for (int i = 0; i < 9; i++) if (c == BC[i]) s = 4'(i);
        return s;
    endfunction : bdec
    // only 0 dB is compatibility type
    function automatic logic dem_ok(input lscr_pkg::lscr_deemph_type d);
        return !d.valid || (d.step <= 3'h4 && d.enhanced == (d.step != 3'h0));
    endfunction : dem_ok
    property p_dem;
        dem_ok(lane0_output_b) && dem_ok(lane1_output_a.deemph) && dem_ok(lane1_output_b.deemph);
    endproperty
    a_dem: assert property (p_dem) else $error("deemphasis decode wrong");
    property p_idle;
        !(lane1_output_a.auto_idle && lane1_output_a.muted)
            && !(lane1_output_b.auto_idle && lane1_output_b.muted);
    endproperty
    a_idle: assert property (p_idle) else $error("mute under auto idle");
    property p_rate;
        lane1_output_a.auto_rate |-> !lane1_output_a.high_rate;
    endproperty
    a_rate: assert property (p_rate) else $error("manual rate under auto");
    // first edge after release sees reset values
    property p_boost;
        !$past(rst) |-> lane1_input.boost_step == bdec({lane1_input.boost_en,
            lane1_input.gain_stage, lane1_input.boost_level})
            && lane1_input.boost_valid == (lane1_input.boost_step != 4'hF);
    endproperty
    a_boost: assert property (p_boost) else $error("boost decode wrong");
    property p_thr;
        !$past(rst) |-> lane1_input.deassert_mv inside {110, 150, 170, 190}
            && lane1_input.assert_mv inside {70, 110, 130, 150};
    endproperty
    a_thr: assert property (p_thr) else $error("threshold pair wrong");
    property p_swing;
        !$past(rst) && !lane1_output_a.swing_valid && !lane1_output_b.swing_valid |->
            lane1_output_a.swing_mv inside {450, 525, 600, 675}
            && lane1_output_b.swing_mv == lane1_output_a.swing_mv;
    endproperty
    a_swing: assert property (p_swing) else $error("fallback swing wrong");
    property p_sda_low;
        sda_out == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("data pin drives high"); // open drain
    // data moves only with bus clock low
    property p_sda_hold;
        scl_in && $past(scl_in) |-> $stable(sda_oe_n);
    endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("data moved with clock high"); // bus
endmodule : lscr_regs_properties
bind lscr_regs lscr_regs_properties u_props (.clk, .rst, .scl_in, .sda_in, .sda_out,
    .sda_oe_n, .lane0_output_b, .lane1_output_a, .lane1_output_b, .lane1_input);
`default_nettype wire

// >>> sim/lscr_host_model.sv
// bus host for the register bank
`timescale 1ns/1ns
`default_nettype none
module lscr_host_model (
    // clock and resolved data line
    input wire logic clk,
    input wire logic sda,
    // host pins; sda_pull high pulls data low
    output logic scl,
    output logic sda_pull
);
    int stretch = 0; // extra low cycles per bit
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one bit: data set with clock low, clock held high two cycles
    task automatic slot(input logic b, output logic r);
        @(negedge clk) sda_pull = ~b;
        repeat (stretch + 1) @(negedge clk);
        scl = 1'b1;
        @(negedge clk) r = sda;
        @(negedge clk) scl = 1'b0;
    endtask : slot
    // start (s = 1) or stop (s = 0): data moves while clock stays high
    task automatic cond(input logic s);
        @(negedge clk) sda_pull = ~s;
        @(negedge clk) scl = 1'b1;
        repeat (2) @(negedge clk);
        sda_pull = s;
        repeat (2) @(negedge clk);
        if (s) scl = 1'b0;
    endtask : cond
    // msb first, then the ack slot
    task automatic xfer(input logic [7:0] t, input logic ai, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) slot(t[i], r[i]);
        slot(ai, a);
    endtask : xfer
    // write v to offset o, or read o into d ending with a not-acknowledge
    task automatic acc(input logic is_rd, input logic [7:0] o, input logic [7:0] v,
        output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic a0, a1, a2, a3;
        cond(1'b1);
        xfer({lscr_pkg::DEF_DEV_ADDR, 1'b0}, 1'b1, r, a0);
        xfer(o, 1'b1, r, a1);
        if (is_rd) begin
            cond(1'b1);
            xfer({lscr_pkg::DEF_DEV_ADDR, 1'b1}, 1'b1, r, a2);
            xfer(8'hFF, 1'b1, d, a3);
        end else begin
            xfer(v, 1'b1, d, a2);
        end
        cond(1'b0);
        ok = ~(a0 | a1 | a2);
    endtask : acc
endmodule : lscr_host_model
`default_nettype wire

// >>> sim/tb.sv
// bench for the register bank
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl, hpull, sda_out, sda_oe_n;
    wire sda = ~(hpull | ~sda_oe_n); // pull-up, either party may pull low
    lscr_pkg::lscr_deemph_type b0;
    lscr_pkg::lscr_tx_type a1, b1;
    lscr_pkg::lscr_rx_type in1;
    int n_fail = 0;
    int num_checks = 0;
    int seed = 75;
    int exp_reg [256]; // register model
    localparam logic [7:0] OFS [11] = '{8'h35, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h40,
        8'h42, 8'h43, 8'h47, 8'h36};
    // directed codes: offset and value
    localparam logic [15:0] V [29] = '{16'h4301, 16'h43E8, 16'h4388, 16'h4390, 16'h43A0,
        16'h3A20, 16'h3A2A, 16'h3A30, 16'h3A32, 16'h3A39, 16'h3A35, 16'h3A37, 16'h3A3B,
        16'h3A3D, 16'h4203, 16'h4207, 16'h420F, 16'h421F, 16'h4700, 16'h4701, 16'h4703,
        16'h4702, 16'h3D00, 16'h3D05, 16'h3D0A, 16'h3D0F, 16'h3910, 16'h3901, 16'h3933};
    always #50 clk = ~clk;
    lscr_regs dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .lane0_output_b(b0), .lane1_output_a(a1), .lane1_output_b(b1),
        .lane1_input(in1));
    lscr_host_model h (.clk(clk), .sda(sda), .scl(scl), .sda_pull(hpull));
    // stored bits per offset
    function automatic int mask(int o);
        case (o)
            8'h35, 8'h3C, 8'h43: return 8'hFF;
            8'h39, 8'h40: return 8'h33;
            8'h3A: return 8'h3F;
            8'h3B, 8'h42: return 8'h7F;
            8'h3D: return 8'h0F;
            8'h47: return 8'h03;
            default: return 8'h00;
        endcase
    endfunction : mask
    // random legal value: listed code or zero reserved bits
    function automatic logic [7:0] pick(int o, logic [31:0] r);
        int b;
        b = (mask(o) == 8'hFF) ? r % 5 : (o == 8'h3A) ? 5 + r % 9 : 14 + r % 4;
        return (mask(o) > 8'h33) ? V[b][7:0] : 8'(r & mask(o));
    endfunction : pick
    function automatic int rval(int o);
        return (o == 8'h3A) ? 8'h20 : (o == 8'h47) ? 8'h02 : (mask(o) > 8'h33) ? 8'h03 : 8'h00;
    endfunction : rval
    function automatic logic [4:0] e_dem(int b);
        int s;
        s = -1;
        for (int i = 0; i < 5; i++) if (b == V[i][7:0]) s = i;
        return {b[7], (s < 0) ? 3'h0 : s[2:0], s >= 0};
    endfunction : e_dem
    function automatic logic [20:0] e_tx(int sw, int de, int ir, int tr);
        int base, mv;
        base = (sw == 8'h07) ? 800 : (sw == 8'h0F) ? 1000 : (sw == 8'h1F) ? 1200 : 600;
        mv = base * (6 + tr) / 8;
        return {e_dem(de), mv[10:0], base != 600 || sw == 8'h03, ir[5], ir[4] & ~ir[5],
            ir[1], ir[0] & ~ir[1]};
    endfunction : e_tx
    function automatic logic [26:0] e_rx(int eq, int th);
        int s, dm [4], am [4];
        dm = '{110, 150, 170, 190};
        am = '{70, 110, 130, 150};
        s = 15;
        for (int i = 0; i < 9; i++) if (eq == V[5 + i][7:0]) s = i;
        return {eq[5:0], s[3:0], s != 15, dm[th[3:2]][7:0], am[th[1:0]][7:0]};
    endfunction : e_rx
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ev);
        num_checks++;
        if (seen !== ev) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, ev, seen);
        end
    endtask : chk
    task automatic chk_outs();
        chk("lane0 b", 32'(b0), 32'(e_dem(exp_reg[8'h35])));
        chk("lane1 a", 32'(a1), 32'(e_tx(exp_reg[8'h3B], exp_reg[8'h3C], exp_reg[8'h39],
            exp_reg[8'h47])));
        chk("lane1 b", 32'(b1), 32'(e_tx(exp_reg[8'h42], exp_reg[8'h43], exp_reg[8'h40],
            exp_reg[8'h47])));
        chk("lane1 in", 32'(in1), 32'(e_rx(exp_reg[8'h3A], exp_reg[8'h3D])));
    endtask : chk_outs
    // write, check, read back
    task automatic op(input logic [7:0] o, input logic [7:0] v);
        logic ok;
        logic [7:0] d;
        h.acc(1'b0, o, v, d, ok);
        exp_reg[o] = v & mask(o);
        chk("write ack", 32'(ok), 32'h1);
        chk_outs();
        h.acc(1'b1, o, 8'h00, d, ok);
        chk("read data", 32'(d), 32'(exp_reg[o]));
    endtask : op
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    // watchdog, well past the run of about 30000 cycles
    initial begin
        repeat (80000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end
    initial begin
        int k;
        for (int i = 0; i < 256; i++) exp_reg[i] = rval(i);
        repeat (20) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk_outs();
        for (int i = 0; i < 11; i++) op(OFS[i], 8'(exp_reg[OFS[i]]));
        $display("test reset values done");
        for (int i = 0; i < 29; i++) op(V[i][15:8], V[i][7:0]);
        $display("test listed codes done");
        h.stretch = 3;
        for (int i = 0; i < 40; i++) begin
            k = $unsigned($random(seed)) % 11;
            op(OFS[k], pick(OFS[k], $random(seed)));
        end
        $display("test random writes done");
        @(negedge clk) rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 256; i++) exp_reg[i] = rval(i);
        repeat (2) @(negedge clk);
        chk_outs();
        $display("test second reset done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
